// ---- dv/ddsp_host.sv ----
// serial host model that frames command words into the port
`timescale 1ns/1ps
`default_nettype none
module ddsp_host (
  // clock
  input wire logic i_sys_clk,
  // serial link
  output logic o_frame_n,
  output logic o_sclk,
  output logic o_sdin,
  input wire logic i_sdo,
  // bits captured from the serial output
  output logic [15:0] o_rx
);
  // idle levels: frame high, clock parked high
  initial begin
    o_frame_n = 1'b1;
    o_sclk = 1'b1;
    o_sdin = 1'b0;
    o_rx = 16'h0000;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // one frame, msb first; each sclk level lasts two sys clocks
  task automatic xfer(input logic [31:0] w, input int nbits, input logic rise);
    int i;
    @(posedge i_sys_clk);
    o_frame_n <= 1'b0;
    repeat (2) @(posedge i_sys_clk);
    for (i = 0; i < nbits; i++) begin
      o_sclk <= ~rise;
      o_sdin <= w[nbits-1-i];
      repeat (2) @(posedge i_sys_clk);
      o_rx <= {o_rx[14:0], i_sdo};
      o_sclk <= rise;
      repeat (2) @(posedge i_sys_clk);
    end
    o_sclk <= 1'b1;
    repeat (2) @(posedge i_sys_clk);
    // released data shows the inverse so a stale level never passes for data
    o_frame_n <= 1'b1;
    o_sdin <= ~o_sdin;
    repeat (3) @(posedge i_sys_clk);
  endtask : xfer
endmodule : ddsp_host
`default_nettype wire

// ---- dv/dual_dac_serial_command_port_tb.sv ----
// self-checking bench for the dual DAC serial command port
`timescale 1ns/1ps
`default_nettype none
`include "ddsp_cfg.svh"
module dual_dac_serial_command_port_tb;
  import ddsp_pkg::*;
  typedef struct packed {logic [15:0] w; logic [11:0] a; logic [11:0] b;} ddsp_row_t;
  // sequential words sent in default chained mode, with dac codes after each
  localparam ddsp_row_t ROWS [0:12] = '{
    {16'h1ABC, 12'hABC, 12'h000}, {16'h4123, 12'hABC, 12'h123}, {16'h3555, 12'hABC, 12'h123},
    {16'h6666, 12'hABC, 12'h123}, {16'h7000, 12'h555, 12'h666}, {16'h8777, 12'h555, 12'h666},
    {16'h0FFF, 12'h555, 12'h666}, {16'hFFFF, 12'h555, 12'h666}, {16'hEAAA, 12'h555, 12'h666},
    {16'h7000, 12'h777, 12'h777}, {16'hB000, 12'h000, 12'h000}, {16'hC000, 12'h800, 12'h800},
    {16'hDABC, 12'h800, 12'h800}};
  logic i_sys_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_ce = 1'b1;
  logic [1:0] i_addr = 2'h0;
  logic [31:0] i_wdata = 32'h0;
  logic frame_n, sclk, sdin, serial_data_out, sdo_oe, sdo_line, buf_pwr, ctrl_mode;
  logic [31:0] rdata, rd;
  logic [11:0] dac_a, dac_b, ctrl_word;
  logic [15:0] rx;
  int errors = 0;
  int num_checks = 0;
  int i;
  always #25 i_sys_clk = ~i_sys_clk;
  ////////////////////////////////////////////////////////////////////////////////
  // design and host; a released serial output reads as the inverse of its last level
  assign sdo_line = sdo_oe ? serial_data_out : ~serial_data_out;
  ddsp_port ddsp_port_inst (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_ce(i_ce),
    .i_frame_n(frame_n), .i_sclk(sclk), .i_sdin(sdin), .o_serial_data_out(serial_data_out),
    .o_serial_data_out_oe(sdo_oe), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(rdata), .o_dac_a(dac_a), .o_dac_b(dac_b), .o_buf_pwr(buf_pwr),
    .o_ctrl_mode(ctrl_mode), .o_ctrl_word(ctrl_word));
  ddsp_host ddsp_host_inst (.i_sys_clk(i_sys_clk), .o_frame_n(frame_n), .o_sclk(sclk),
    .o_sdin(sdin), .i_sdo(sdo_line), .o_rx(rx));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // read data stand only in the cycle after the strobe, zero after
  task automatic regrd(input logic [1:0] a, output logic [31:0] d);
    @(posedge i_sys_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1 d = rdata;
    @(posedge i_sys_clk);
    #1 chk(rdata, 32'h0, "rdata idle");
  endtask : regrd
  task automatic regwr(input logic [1:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask : regwr
  // one frame, with buffer power and output enable watched mid-frame
  task automatic send(input logic [31:0] w, input int n, input logic rise, input logic oe);
    fork
      ddsp_host_inst.xfer(w, n, rise);
      begin
        repeat (5) @(posedge i_sys_clk);
        #1 chk(32'(buf_pwr), 32'h1, "buf_pwr in frame");
        chk(32'(sdo_oe), 32'(oe), "sdo_oe in frame");
      end
    join
    #1 chk(32'(buf_pwr), 32'h0, "buf_pwr after frame");
  endtask : send
  task automatic dacs(input logic [11:0] a, input logic [11:0] b);
    chk(32'(dac_a), 32'(a), "dac_a");
    chk(32'(dac_b), 32'(b), "dac_b");
  endtask : dacs
  task automatic report_and_stop;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop
  ////////////////////////////////////////////////////////////////////////////////
  // watchdog: the whole run needs well under 10000 cycles
  initial begin
    #(20000 * 50);
    errors++;
    report_and_stop();
  end
  // main sequence
  initial begin
    repeat (20) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    #1 dacs(12'h000, 12'h000);
    chk(32'(sdo_oe), 32'h1, "sdo_oe reset");
    regrd(`DDSP_ADDR_STATUS, rd);
    chk(rd, 32'h1, "status reset");
    for (i = 0; i < 13; i++) begin
      send({16'h0, ROWS[i].w}, 16, 1'b0, 1'b1);
      dacs(ROWS[i].a, ROWS[i].b);
    end
    chk(32'(ctrl_mode), 32'h1, "ctrl_mode");
    chk(32'(ctrl_word), 32'hABC, "ctrl_word out");
    regrd(`DDSP_ADDR_CTRL_WORD, rd);
    chk(rd, 32'hABC, "ctrl_word");
    // chained: the first word ripples out, the last 16 bits act at frame rise
    send(32'h1123_4456, 32, 1'b0, 1'b1);
    dacs(12'h800, 12'h456);
    chk(32'(rx), 32'h1123, "chain out");
    send(32'h1F, 8, 1'b0, 1'b1);
    dacs(12'h800, 12'h456);
    send({16'h0, DDSP_CHAIN_OFF, 12'h000}, 16, 1'b0, 1'b1);
    // the output stays driven until the first standalone frame starts
    chk(32'(sdo_oe), 32'h1, "sdo_oe after chain off");
    regrd(`DDSP_ADDR_STATUS, rd);
    chk(rd, 32'h4, "status chain off");
    // standalone: short frame aborts, clocks past the 16th are ignored
    send(32'h1F, 8, 1'b0, 1'b0);
    dacs(12'h800, 12'h456);
    chk(32'(sdo_oe), 32'h0, "sdo_oe standalone");
    send(32'h0001_5A5F, 20, 1'b0, 1'b0);
    dacs(12'h5A5, 12'h456);
    send({16'h0, DDSP_RDBK_A, 12'h000}, 16, 1'b0, 1'b0);
    regrd(`DDSP_ADDR_STATUS, rd);
    chk(rd, 32'hC, "status readback");
    send(32'h0, 16, 1'b0, 1'b1);
    chk(32'(rx), 32'h05A5, "readback");
    send({16'h0, DDSP_RISE_EDGE, 12'h000}, 16, 1'b0, 1'b0);
    regrd(`DDSP_ADDR_STATUS, rd);
    chk(rd, 32'h6, "status rising");
    send(32'h1123, 16, 1'b1, 1'b0);
    dacs(12'h123, 12'h456);
    send({16'h0, DDSP_CLR_ZERO, 12'h000}, 16, 1'b1, 1'b0);
    dacs(12'h000, 12'h000);
    // defaults restored by software; a write to a read-only place is ignored
    send(32'h1321, 16, 1'b1, 1'b0);
    regwr(`DDSP_ADDR_STATUS, 32'h1);
    regwr(`DDSP_ADDR_DAC_A, 32'hFFF);
    regrd(`DDSP_ADDR_DAC_A, rd);
    chk(rd, 32'h0, "dac_a defaults");
    regrd(`DDSP_ADDR_STATUS, rd);
    chk(rd, 32'h1, "status defaults");
    chk(32'(ctrl_word), 32'h0, "ctrl_word defaults");
    send(32'h1ABC, 16, 1'b0, 1'b1);
    dacs(12'hABC, 12'h000);
    // with the clock enable low a defaults write must leave every register alone
    @(posedge i_sys_clk);
    i_ce <= 1'b0;
    regwr(`DDSP_ADDR_STATUS, 32'h1);
    @(posedge i_sys_clk);
    i_ce <= 1'b1;
    #1 dacs(12'hABC, 12'h000);
    report_and_stop();
  end
endmodule : dual_dac_serial_command_port_tb
`default_nettype wire

// ---- inc/ddsp_cfg.svh ----
// constants of the dual DAC serial command port
`ifndef DDSP_CFG_SVH
`define DDSP_CFG_SVH
`define DDSP_WORD_BITS 16
`define DDSP_DATA_BITS 12
`define DDSP_CMD_BITS 4
`define DDSP_CNT_BITS 5
`define DDSP_ZERO_SCALE 12'h000
`define DDSP_MID_SCALE 12'h800
`define DDSP_ADDR_BITS 2
`define DDSP_ADDR_STATUS 2'h0
`define DDSP_ADDR_DAC_A 2'h1
`define DDSP_ADDR_DAC_B 2'h2
`define DDSP_ADDR_CTRL_WORD 2'h3
`define DDSP_ADDR_COMMAND 2'h0
`define DDSP_STAT_CHAIN 0
`define DDSP_STAT_RISE 1
`define DDSP_STAT_CTRL 2
`define DDSP_STAT_RDBK 3
`define DDSP_STAT_BUFPWR 4
`define DDSP_CMDBIT_DEFAULTS 0
`endif

// ---- inc/ddsp_pkg.sv ----
// types of the dual DAC serial command port
package ddsp_pkg;
  typedef enum logic [1:0] {
    DDSP_IDLE = 2'h0,
    DDSP_SHIFT = 2'h1,
    DDSP_DONE = 2'h3
  } ddsp_state_t;
  typedef enum logic [3:0] {
    DDSP_NOP = 4'h0,
    DDSP_LDUP_A = 4'h1,
    DDSP_RDBK_A = 4'h2,
    DDSP_LOAD_A = 4'h3,
    DDSP_LDUP_B = 4'h4,
    DDSP_RDBK_B = 4'h5,
    DDSP_LOAD_B = 4'h6,
    DDSP_UPD_AB = 4'h7,
    DDSP_LOAD_AB = 4'h8,
    DDSP_CHAIN_OFF = 4'h9,
    DDSP_RISE_EDGE = 4'hA,
    DDSP_CLR_ZERO = 4'hB,
    DDSP_CLR_MID = 4'hC,
    DDSP_CTRL_WORD = 4'hD,
    DDSP_RESERVED = 4'hE,
    DDSP_NOP2 = 4'hF
  } ddsp_cmd_t;
endpackage : ddsp_pkg

// ---- logic/ddsp_port.sv ----
// serial command port of a dual 12-bit DAC
`timescale 1ns/1ps
`default_nettype none
`include "ddsp_cfg.svh"
module ddsp_port (
  // clock, reset, enable
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  // serial link from the host
  input wire logic i_frame_n,
  input wire logic i_sclk,
  input wire logic i_sdin,
  output logic o_serial_data_out,
  output logic o_serial_data_out_oe,
  // register port
  input wire logic [`DDSP_ADDR_BITS-1:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // DAC side
  output logic [`DDSP_DATA_BITS-1:0] o_dac_a,
  output logic [`DDSP_DATA_BITS-1:0] o_dac_b,
  output logic o_buf_pwr,
  output logic o_ctrl_mode,
  output logic [`DDSP_DATA_BITS-1:0] o_ctrl_word
);
  import ddsp_pkg::*;

  localparam int W = `DDSP_WORD_BITS;
  localparam int D = `DDSP_DATA_BITS;

  ////////////////////////////////////////////////////////////////////////////
  // edge detection; inputs are already synchronous to i_sys_clk
  logic sclk_q_reg, sclk_q_next, frame_q_reg, frame_q_next;
  logic sclk_rise, sclk_fall, frame_fall, frame_rise, sample_edge, launch_edge;
  assign sclk_rise = i_sclk & ~sclk_q_reg;
  assign sclk_fall = ~i_sclk & sclk_q_reg;
  assign frame_fall = ~i_frame_n & frame_q_reg;
  assign frame_rise = i_frame_n & ~frame_q_reg;

  // state of the serial engine and the DAC side
  ddsp_state_t state_reg, state_next;
  logic [W-1:0] sreg_reg, sreg_next;
  logic [`DDSP_CNT_BITS-1:0] cnt_reg, cnt_next;
  logic chain_reg, chain_next, rise_reg, rise_next, rdbk_reg, rdbk_next;
  logic bufpwr_reg, bufpwr_next, ctrl_reg, ctrl_next;
  logic sdo_reg, sdo_next, sdo_oe_reg, sdo_oe_next;
  logic [D-1:0] in_a_reg, in_a_next, in_b_reg, in_b_next;
  logic [D-1:0] dac_a_reg, dac_a_next, dac_b_reg, dac_b_next;
  logic [D-1:0] cword_reg, cword_next;
  logic [31:0] rdata_reg, rdata_next;
  logic exec_en;
  logic [W-1:0] exec_word;
  logic [D-1:0] exec_data;
  logic soft_defaults;

  // the active sampling edge is programmable; the serial output moves on the other
  assign sample_edge = rise_reg ? sclk_rise : sclk_fall;
  assign launch_edge = rise_reg ? sclk_fall : sclk_rise;
  assign soft_defaults = i_wr && (i_addr == `DDSP_ADDR_COMMAND) &&
                         i_wdata[`DDSP_CMDBIT_DEFAULTS];
  // data field of the word that acts in this cycle
  assign exec_data = exec_word[D-1:0];

  // shift word with the next serial bit appended at the bottom
  function automatic logic [W-1:0] shift_in(input logic [W-1:0] s, input logic b);
    shift_in = {s[W-2:0], b};
  endfunction : shift_in

  // value returned by a readback command
  function automatic logic [D-1:0] rdbk_val(input logic [W-1:0] w);
    rdbk_val = (ddsp_cmd_t'(w[W-1:D]) == DDSP_RDBK_B) ? dac_b_reg : dac_a_reg;
  endfunction : rdbk_val

  ////////////////////////////////////////////////////////////////////////////
  // serial framing: counter, shift register, buffer power and serial output
  always_comb begin
    state_next = state_reg;
    sreg_next = sreg_reg;
    cnt_next = cnt_reg;
    bufpwr_next = bufpwr_reg;
    sdo_next = sdo_reg;
    sdo_oe_next = sdo_oe_reg;
    exec_en = 1'b0;
    exec_word = sreg_reg;
    sclk_q_next = i_sclk;
    frame_q_next = i_frame_n;
    if (frame_fall) begin
      // counter restarts; buffers wake only for a frame
      state_next = DDSP_SHIFT;
      cnt_next = '0;
      bufpwr_next = 1'b1;
      sdo_next = sreg_reg[W-1];
      sdo_oe_next = chain_reg | rdbk_reg;
    end else if (frame_rise) begin
      // a chained word acts here; a short standalone word is dropped
      if (state_reg == DDSP_SHIFT && chain_reg && cnt_reg >= 5'(W)) begin
        exec_en = 1'b1;
      end
      state_next = DDSP_IDLE;
      bufpwr_next = 1'b0;
      sdo_oe_next = chain_reg;
    end else if (state_reg == DDSP_SHIFT) begin
      if (sample_edge) begin
        sreg_next = shift_in(sreg_reg, i_sdin);
        if (cnt_reg != 5'(W)) begin
          cnt_next = cnt_reg + 5'h1;
        end
        if (!chain_reg && cnt_reg == 5'(W - 1)) begin
          exec_en = 1'b1;
          exec_word = shift_in(sreg_reg, i_sdin);
          state_next = DDSP_DONE;
        end
      end
      if (launch_edge) begin
        sdo_next = sreg_reg[W-1];
      end
    end
    // a readback command swaps the shift word for the DAC code to be sent back
    if (exec_en && (ddsp_cmd_t'(exec_word[W-1:D]) inside {DDSP_RDBK_A, DDSP_RDBK_B})) begin
      sreg_next = {4'h0, rdbk_val(exec_word)};
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      state_reg <= DDSP_IDLE;
      sreg_reg <= '0;
      cnt_reg <= '0;
      bufpwr_reg <= 1'b0;
      sdo_reg <= 1'b0;
      sdo_oe_reg <= 1'b1;
      sclk_q_reg <= 1'b0;
      frame_q_reg <= 1'b1;
    end else if (i_ce) begin
      state_reg <= state_next;
      sreg_reg <= sreg_next;
      cnt_reg <= cnt_next;
      bufpwr_reg <= bufpwr_next;
      sdo_reg <= sdo_next;
      sdo_oe_reg <= sdo_oe_next;
      sclk_q_reg <= sclk_q_next;
      frame_q_reg <= frame_q_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command decode; the load pin is taken as held low, so updates are immediate
  always_comb begin
    logic [D-1:0] d;
    d = exec_data;
    in_a_next = in_a_reg;
    in_b_next = in_b_reg;
    dac_a_next = dac_a_reg;
    dac_b_next = dac_b_reg;
    chain_next = chain_reg;
    rise_next = rise_reg;
    ctrl_next = ctrl_reg;
    cword_next = cword_reg;
    // a pending readback stays until the next frame starts shifting it out
    rdbk_next = frame_fall ? 1'b0 : rdbk_reg;
    // software defaults first, so a command landing in the same cycle still wins
    if (soft_defaults) begin
      in_a_next = `DDSP_ZERO_SCALE;
      in_b_next = `DDSP_ZERO_SCALE;
      dac_a_next = `DDSP_ZERO_SCALE;
      dac_b_next = `DDSP_ZERO_SCALE;
      chain_next = 1'b1;
      rise_next = 1'b0;
      ctrl_next = 1'b0;
      cword_next = '0;
      rdbk_next = 1'b0;
    end
    if (exec_en) begin
      unique case (ddsp_cmd_t'(exec_word[W-1:D]))
        DDSP_LDUP_A: begin
          in_a_next = d;
          dac_a_next = d;
        end
        DDSP_LDUP_B: begin
          in_b_next = d;
          dac_b_next = d;
        end
        DDSP_LOAD_A: in_a_next = d;
        DDSP_LOAD_B: in_b_next = d;
        DDSP_LOAD_AB: begin
          in_a_next = d;
          in_b_next = d;
        end
        DDSP_UPD_AB: begin
          dac_a_next = in_a_next;
          dac_b_next = in_b_next;
        end
        DDSP_RDBK_A, DDSP_RDBK_B: rdbk_next = 1'b1;
        DDSP_CHAIN_OFF: chain_next = 1'b0;
        DDSP_RISE_EDGE: rise_next = 1'b1;
        DDSP_CLR_ZERO: begin
          dac_a_next = `DDSP_ZERO_SCALE;
          dac_b_next = `DDSP_ZERO_SCALE;
        end
        DDSP_CLR_MID: begin
          dac_a_next = `DDSP_MID_SCALE;
          dac_b_next = `DDSP_MID_SCALE;
        end
        DDSP_CTRL_WORD: begin
          ctrl_next = 1'b1;
          cword_next = d;
        end
        DDSP_NOP, DDSP_NOP2, DDSP_RESERVED: ;
      endcase
    end
  end

  // power-on defaults; software defaults arrive through the decode above
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      in_a_reg <= `DDSP_ZERO_SCALE;
      in_b_reg <= `DDSP_ZERO_SCALE;
      dac_a_reg <= `DDSP_ZERO_SCALE;
      dac_b_reg <= `DDSP_ZERO_SCALE;
      chain_reg <= 1'b1;
      rise_reg <= 1'b0;
      ctrl_reg <= 1'b0;
      cword_reg <= '0;
      rdbk_reg <= 1'b0;
    end else if (i_ce) begin
      in_a_reg <= in_a_next;
      in_b_reg <= in_b_next;
      dac_a_reg <= dac_a_next;
      dac_b_reg <= dac_b_next;
      chain_reg <= chain_next;
      rise_reg <= rise_next;
      ctrl_reg <= ctrl_next;
      cword_reg <= cword_next;
      rdbk_reg <= rdbk_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register read port: data stands one cycle after the strobe, else zero
  always_comb begin
    rdata_next = 32'h0;
    if (i_rd) begin
      unique case (i_addr)
        `DDSP_ADDR_STATUS: rdata_next = {27'h0, bufpwr_reg, rdbk_reg, ctrl_reg,
                                         rise_reg, chain_reg};
        `DDSP_ADDR_DAC_A: rdata_next = {20'h0, dac_a_reg};
        `DDSP_ADDR_DAC_B: rdata_next = {20'h0, dac_b_reg};
        `DDSP_ADDR_CTRL_WORD: rdata_next = {20'h0, cword_reg};
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      rdata_reg <= 32'h0;
    end else if (i_ce) begin
      rdata_reg <= rdata_next;
    end
  end

  // outputs straight from flops
  assign o_serial_data_out = sdo_reg;
  assign o_serial_data_out_oe = sdo_oe_reg;
  assign o_rdata = rdata_reg;
  assign o_dac_a = dac_a_reg;
  assign o_dac_b = dac_b_reg;
  assign o_buf_pwr = bufpwr_reg;
  assign o_ctrl_mode = ctrl_reg;
  assign o_ctrl_word = cword_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  a_buf_wake: assert property (i_ce && frame_fall |=> o_buf_pwr)
    else $error("buffers not powered after frame start");
  a_buf_sleep: assert property (i_ce && frame_rise |=> !o_buf_pwr)
    else $error("buffers still powered after frame end");
  a_defaults_reset: assert property ($fell(i_rst) |-> chain_reg && !rise_reg)
    else $error("wrong mode defaults after reset");
  a_zero_at_reset: assert property ($fell(i_rst) |-> o_dac_a == 12'h000 && o_dac_b == 12'h000)
    else $error("DAC not at zero scale after reset");
  a_ctrl_enter: assert property (i_ce && exec_en && exec_word[15:12] == 4'hD
      |=> o_ctrl_mode && o_ctrl_word == $past(exec_data))
    else $error("control word not entered");
  a_midscale_clear: assert property (i_ce && exec_en && exec_word[15:12] == 4'hC
      && !soft_defaults |=> o_dac_a == 12'h800 && o_dac_b == 12'h800)
    else $error("midscale clear failed");
  a_ldup_a: assert property (i_ce && exec_en && exec_word[15:12] == 4'h1
      && !soft_defaults |=> o_dac_a == $past(exec_data) && $stable(o_dac_b))
    else $error("load and update A failed");
  a_standalone_16: assert property (exec_en && !chain_reg |-> cnt_reg == 5'h0F && sample_edge)
    else $error("standalone word acted on the wrong edge");
  a_chain_on_frame: assert property (exec_en && chain_reg |-> frame_rise && cnt_reg >= 5'h10)
    else $error("chained word acted outside frame end");
  a_done_ignores: assert property (state_reg == DDSP_DONE && !frame_fall |=> $stable(cnt_reg))
    else $error("counter moved after word completed");

  c_standalone_word: cover property (exec_en && !chain_reg);
  c_chained_word: cover property (exec_en && chain_reg);
  c_readback: cover property (rdbk_reg && frame_fall);
  c_abort: cover property (frame_rise && state_reg == DDSP_SHIFT && cnt_reg != 5'h00
      && cnt_reg < 5'h10);
endmodule : ddsp_port
`default_nettype wire
